// *** bst_test_port.sv ***
// Boundary-scan test access port with instruction, bypass, id, user and scan registers
// Function
// - Instruction register is 10 bits, shifted in from data input.
// - User signature is 32 bits: 7 configured bits, 25 fixed.
// - Bypass places a single flip-flop between data input and output.
// - Sample/preload captures pins ORed with core outputs and accepts an output pattern by shifting.
// - Extest drives scan pattern to outputs and captures input pins.
// - Usercode shifts the user signature out of the data output.
// - Idcode shifts the identification register out of the data output.
// - Configuration instructions let the host load device configuration.
// - Scan chain length depends on device size, 480 to 1440 cells.
`timescale 1ns/1ps
`default_nettype none
module bst_test_port
  import bst_pkg::*;
#(
  parameter int BSR_LEN = BSR_MIN_LEN
)(
  input  wire logic                  core_clk,
  input  wire logic                  reset,
  input  wire logic                  tck,
  input  wire logic                  tmsIn,
  input  wire logic                  tdiIn,
  input  wire logic                  trstN,
  output logic                       tdoOut,
  output logic                       tdoOe,
  input  wire logic [USER_CFG_W-1:0] userCfg,
  input  wire logic [BSR_LEN-1:0]    pinIn,
  input  wire logic [BSR_LEN-1:0]    coreOut,
  output logic      [BSR_LEN-1:0]    pinOut,
  output logic                       cfgWrite,
  output logic                       cfgBit,
  output logic                       cfgStart
);
  bst_state_e            state;
  bst_state_e            next_state;
  bst_link_s             link;
  logic [IR_WIDTH-1:0]   irShift;
  logic [IR_WIDTH-1:0]   irActive;
  logic [USER_WIDTH-1:0] drShift32;
  logic                  bypassReg;
  logic [BSR_LEN-1:0]    bsrShift;
  logic [BSR_LEN-1:0]    bsrUpdate;
  logic                  cfgTog;
  logic                  startTog;
  logic                  cfgData;
  logic [2:0]            cfgSync;
  logic [2:0]            startSync;
  logic                  cfgBitHold;
  logic                  cfgBitSync;

  assign link = '{tms: tmsIn, tdi: tdiIn};

  wire isExtest  = (irActive == OP_EXTEST);
  wire isSample  = (irActive == OP_SAMPLE);
  wire isBsr     = isExtest | isSample;
  wire isId      = (irActive == OP_IDCODE);
  wire isUser    = (irActive == OP_USERCODE);
  wire isCfg     = (irActive == OP_CFG_LOAD);
  wire isStart   = (irActive == OP_CFG_START);
  wire is32      = isId | isUser;
  wire [USER_WIDTH-1:0] userWord = {USER_FIXED, userCfg};
  wire [BSR_LEN-1:0]    capVal   = isExtest ? pinIn : (pinIn | coreOut);

  // Standard state walk
  always_comb
  begin
    unique case (state)
      ST_RESET:  next_state = link.tms ? ST_RESET  : ST_IDLE;
      ST_IDLE:   next_state = link.tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: next_state = link.tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: next_state = link.tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  next_state = link.tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: next_state = link.tms ? ST_UP_DR  : ST_PA_DR;
      ST_PA_DR:  next_state = link.tms ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: next_state = link.tms ? ST_UP_DR  : ST_SH_DR;
      ST_UP_DR:  next_state = link.tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: next_state = link.tms ? ST_RESET  : ST_CAP_IR;
      ST_CAP_IR: next_state = link.tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  next_state = link.tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: next_state = link.tms ? ST_UP_IR  : ST_PA_IR;
      ST_PA_IR:  next_state = link.tms ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: next_state = link.tms ? ST_UP_IR  : ST_SH_IR;
      ST_UP_IR:  next_state = link.tms ? ST_SEL_DR : ST_IDLE;
    endcase
  end

  // Test reset is synchronous to tck; hold trstN low with tck running
  always_ff @(posedge tck)
  begin
    if (!trstN)
      state <= ST_RESET;
    else
      state <= next_state;
  end

  // Instruction register
  always_ff @(posedge tck)
  begin
    if (!trstN || state == ST_RESET)
    begin
      irShift  <= OP_IDCODE;
      irActive <= OP_IDCODE;
    end
    else if (state == ST_CAP_IR)
      irShift <= {{(IR_WIDTH-2){1'b0}}, IR_CAPTURE};
    else if (state == ST_SH_IR)
      irShift <= {link.tdi, irShift[IR_WIDTH-1:1]};
    else if (state == ST_UP_IR)
      irActive <= irShift;
  end

  // Data registers
  always_ff @(posedge tck)
  begin
    if (!trstN)
    begin
      bypassReg <= 1'b0;
      drShift32 <= '0;
      bsrShift  <= '0;
      bsrUpdate <= '0;
      cfgTog    <= 1'b0;
      startTog  <= 1'b0;
      cfgData   <= 1'b0;
    end
    else
    begin
      if (state == ST_CAP_DR)
      begin
        bypassReg <= 1'b0;
        if (isId)
          drShift32 <= ID_VALUE;
        else if (isUser)
          drShift32 <= userWord;
        if (isBsr)
          bsrShift <= capVal;
      end
      else if (state == ST_SH_DR)
      begin
        bypassReg <= link.tdi;
        drShift32 <= {link.tdi, drShift32[USER_WIDTH-1:1]};
        if (isBsr)
          bsrShift <= {link.tdi, bsrShift[BSR_LEN-1:1]};
        if (isCfg)
        begin
          cfgData <= link.tdi;
          cfgTog  <= ~cfgTog;
        end
      end
      else if (state == ST_UP_DR)
      begin
        if (isBsr)
          bsrUpdate <= bsrShift;
        if (isStart)
          startTog <= ~startTog;
      end
    end
  end

  wire tdoSel = (state == ST_SH_IR) ? irShift[0] :
                isBsr ? bsrShift[0] :
                is32  ? drShift32[0] : bypassReg;
  wire tdoEn  = (state == ST_SH_IR) || (state == ST_SH_DR);

  // Output changes on falling edge so host samples a settled bit
  always_ff @(negedge tck)
  begin
    if (!trstN)
    begin
      tdoOut <= 1'b0;
      tdoOe  <= 1'b0;
    end
    else
    begin
      tdoOut <= tdoSel;
      tdoOe  <= tdoEn;
    end
  end

  // Pins follow the core unless extest owns them or test reset drives them low
  always_ff @(posedge tck)
  begin
    if (!trstN)
      pinOut <= '0;
    else
      pinOut <= isExtest ? bsrUpdate : coreOut;
  end

  // Configuration bits cross to core_clk by toggle; the data bit stays stable
  // only until the next shifted bit, so shifts must be spaced well beyond the sync delay
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      cfgSync    <= '0;
      startSync  <= '0;
      cfgBitHold <= 1'b0;
      cfgBitSync <= 1'b0;
      cfgWrite   <= 1'b0;
      cfgBit     <= 1'b0;
      cfgStart   <= 1'b0;
    end
    else
    begin
      cfgSync    <= {cfgSync[1:0], cfgTog};
      startSync  <= {startSync[1:0], startTog};
      cfgBitHold <= cfgData;
      cfgBitSync <= cfgBitHold;
      cfgWrite   <= cfgSync[2] ^ cfgSync[1];
      cfgBit     <= cfgBitSync;
      cfgStart   <= startSync[2] ^ startSync[1];
    end
  end

  a_exit_reset: assert property (@(posedge tck) disable iff (!trstN)
    (state == ST_RESET && !link.tms) |=> state == ST_IDLE)
    else $error("Reset state did not step to idle");
  a_ir_update: assert property (@(posedge tck) disable iff (!trstN)
    state == ST_UP_IR |=> irActive == $past(irShift))
    else $error("Instruction not loaded on update");
  a_bypass_path: assert property (@(posedge tck) disable iff (!trstN)
    (state == ST_SH_DR && irActive == OP_BYPASS) |=> bypassReg == $past(link.tdi))
    else $error("Bypass bit did not follow input");
  a_id_capture: assert property (@(posedge tck) disable iff (!trstN)
    (state == ST_CAP_DR && isId) |=> drShift32 == ID_VALUE)
    else $error("Identification not captured");
  a_user_capture: assert property (@(posedge tck) disable iff (!trstN)
    (state == ST_CAP_DR && isUser) |=> drShift32[USER_WIDTH-1:USER_CFG_W] == USER_FIXED)
    else $error("User signature fixed part wrong");
  a_sample_capture: assert property (@(posedge tck) disable iff (!trstN)
    (state == ST_CAP_DR && isSample) |=> bsrShift == $past(capVal))
    else $error("Sample capture missed pins");
  a_extest_drive: assert property (@(posedge tck) disable iff (!trstN)
    (isExtest && $stable(irActive)) |=> pinOut == $past(bsrUpdate))
    else $error("Extest pattern not on pins");
  a_cfg_pulse: assert property (@(posedge core_clk) disable iff (reset)
    cfgWrite |=> !cfgWrite)
    else $error("Configuration strobe longer than one cycle");
endmodule // bst_test_port
`default_nettype wire

// *** bst_pkg.sv ***
// Shared constants and types for the boundary-scan test port
package bst_pkg;
  localparam int IR_WIDTH     = 10;
  localparam int USER_WIDTH   = 32;
  localparam int USER_CFG_W   = 7;
  localparam int USER_FIX_W   = 25;
  localparam int ID_WIDTH     = 32;
  localparam int BSR_MIN_LEN  = 480;
  localparam int BSR_MAX_LEN  = 1440;
  // Instruction codes; values are arbitrary
  localparam logic [9:0] OP_EXTEST    = 10'h000;
  localparam logic [9:0] OP_SAMPLE    = 10'h055;
  localparam logic [9:0] OP_IDCODE    = 10'h006;
  localparam logic [9:0] OP_USERCODE  = 10'h007;
  localparam logic [9:0] OP_CFG_LOAD  = 10'h002;
  localparam logic [9:0] OP_CFG_START = 10'h003;
  localparam logic [9:0] OP_BYPASS    = 10'h3ff;
  localparam logic [1:0] IR_CAPTURE   = 2'h1;
  // Identification value; arbitrary neutral value
  localparam logic [31:0] ID_VALUE    = 32'h0a5a5001;
  localparam logic [24:0] USER_FIXED  = 25'h0000ace;

  typedef enum logic [3:0] {
    ST_RESET  = 4'h0, ST_IDLE   = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3,
    ST_SH_DR  = 4'h4, ST_EX1_DR = 4'h5, ST_PA_DR  = 4'h6, ST_EX2_DR = 4'h7,
    ST_UP_DR  = 4'h8, ST_SEL_IR = 4'h9, ST_CAP_IR = 4'ha, ST_SH_IR  = 4'hb,
    ST_EX1_IR = 4'hc, ST_PA_IR  = 4'hd, ST_EX2_IR = 4'he, ST_UP_IR  = 4'hf
  } bst_state_e;

  typedef struct packed {
    logic tms;
    logic tdi;
  } bst_link_s;
endpackage

// *** bst_host_model.sv ***
// Test controller model that walks the port and shifts data on the test clock
`timescale 1ns/1ps
`default_nettype none
module bst_host_model
  import bst_pkg::*;
#(
  parameter int W = BSR_MAX_LEN
)(
  input  wire logic tck,
  input  wire logic tdoOut,
  output var logic  tmsIn,
  output var logic  tdiIn
);
  logic seen;
  initial
  begin
    tmsIn = 1'b1;
    tdiIn = 1'b0;
  end
  task automatic step(input logic m, input logic d);
    @(posedge tck);
    seen = tdoOut;
    tmsIn <= m;
    tdiIn <= d;
  endtask
  // Data line toggles outside shifting so stale bits never pass as data
  task automatic walk(input int n, input logic m);
    for (int i = 0; i < n; i++)
      step(m, ~tdiIn);
  endtask
  // Capture, shift, update walk from idle, LSB first
  task automatic shift(input logic ir, input int n, input logic [W-1:0] din,
                       output logic [W-1:0] dout);
    dout = '0;
    step(1'b1, ~tdiIn);
    if (ir)
      step(1'b1, ~tdiIn);
    walk(2, 1'b0);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i]);
      if (i > 0)
        dout[i-1] = seen;
    end
    step(1'b1, ~tdiIn);
    dout[n-1] = seen;
    walk(3, 1'b0);
  endtask
endmodule // bst_host_model
`default_nettype wire

// *** bst_test_port_test.sv ***
// Self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
`default_nettype none
module bst_test_port_test;
  import bst_pkg::*;
  localparam int L = BSR_MIN_LEN;
  logic         core_clk = 0, tck = 0, reset = 1, trstN = 0;
  logic         tmsIn, tdiIn, tdoOut, tdoOe, cfgWrite, cfgBit, cfgStart;
  logic [6:0]   userCfg = '0;
  logic [L-1:0] pinIn = '0, coreOut = '0, pinOut, pat, got;
  logic [31:0]  rnd = 32'h2b;
  logic [9:0]   byOp [2] = '{OP_BYPASS, 10'h123};
  logic         gotQ[$], expQ[$];
  int           num_errors = 0, samples_checked = 0, cyc = 0, starts = 0;
  int           oeCnt = 0, oeBase = 0;
  always #20 core_clk = ~core_clk;
  always #7.5 tck = ~tck;
  bst_test_port #(.BSR_LEN(L)) bst_test_port_i (.core_clk, .reset, .tck, .tmsIn, .tdiIn,
    .trstN, .tdoOut, .tdoOe, .userCfg, .pinIn, .coreOut, .pinOut, .cfgWrite, .cfgBit,
    .cfgStart);
  bst_host_model #(.W(L)) bst_host_model_i (.tck, .tdoOut, .tmsIn, .tdiIn);
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic check(input string what, input logic [L-1:0] seen, input logic [L-1:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic scramble;
    @(posedge core_clk);
    for (int i = 0; i < L / 32; i++)
    begin
      rnd = lfsr(rnd);
      pinIn[i*32 +: 32] <= rnd;
      coreOut[i*32 +: 32] <= ~lfsr(rnd);
    end
    userCfg <= rnd[6:0];
  endtask
  task automatic load_ir(input logic [9:0] op);
    bst_host_model_i.shift(1'b1, IR_WIDTH, L'(op), got);
    check("ir capture", got[9:0], IR_CAPTURE);
  endtask
  // Enable is launched on the falling edge, so it is settled at the rising one
  always @(posedge tck)
    oeCnt += int'(tdoOe === 1'b1);
  always @(posedge core_clk)
  begin
    cyc++;
    if (cfgWrite === 1'b1)
      gotQ.push_back(cfgBit);
    starts += int'(cfgStart === 1'b1);
    if (cyc == 5000)
    begin
      num_errors++;
      end_sim;
    end
  end
  initial
  begin
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    trstN <= 1'b1;
    scramble;
    bst_host_model_i.walk(2, 1'b0);
    bst_host_model_i.shift(1'b0, ID_WIDTH, '0, got);
    check("idcode", got[31:0], ID_VALUE);
    load_ir(OP_USERCODE);
    bst_host_model_i.shift(1'b0, USER_WIDTH, '0, got);
    check("usercode", got[31:0], {USER_FIXED, userCfg});
    // Bypass and an unknown opcode must both use the single-bit path
    for (int k = 0; k < 2; k++)
    begin
      load_ir(byOp[k]);
      rnd = lfsr(rnd);
      pat = {(L/32){rnd}};
      bst_host_model_i.shift(1'b0, 16, pat, got);
      check("bypass", got[15:0], {pat[14:0], 1'b0});
    end
    load_ir(OP_SAMPLE);
    pat = ~pinIn;
    bst_host_model_i.shift(1'b0, L, pat, got);
    check("sample", got, pinIn | coreOut);
    // Pins are launched on the edge that ends the walk; look once settled
    @(negedge tck);
    check("pins normal", pinOut, coreOut);
    load_ir(OP_EXTEST);
    @(negedge tck);
    check("extest drive", pinOut, pat);
    scramble;
    bst_host_model_i.shift(1'b0, L, pat, got);
    check("extest capture", got, pinIn);
    load_ir(OP_CFG_LOAD);
    for (int k = 0; k < 4; k++)
    begin
      rnd = lfsr(rnd);
      expQ.push_back(rnd[0]);
      bst_host_model_i.shift(1'b0, 1, L'(rnd[0]), got);
      // Spacing keeps each bit clear of the toggle crossing
      bst_host_model_i.walk(14, 1'b0);
    end
    load_ir(OP_CFG_START);
    bst_host_model_i.shift(1'b0, 1, '0, got);
    repeat (10) @(posedge core_clk);
    check("cfg count", L'(gotQ.size()), L'(expQ.size()));
    foreach (expQ[k])
      check("cfg bit", L'(gotQ[k]), L'(expQ[k]));
    check("cfg start", L'(starts), L'(1));
    bst_host_model_i.walk(5, 1'b1);
    bst_host_model_i.walk(2, 1'b0);
    oeBase = oeCnt;
    bst_host_model_i.shift(1'b0, ID_WIDTH, '0, got);
    check("tms reset id", got[31:0], ID_VALUE);
    check("tdo enable", L'(oeCnt - oeBase), L'(ID_WIDTH));
    end_sim;
  end
endmodule // bst_test_port_test
`default_nettype wire
